/* File: bench/i2c_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model
(
	// clock
	input  wire logic mclk_i,
	// bus lines
	output var  logic scl_o,
	output var  logic sda_pull_o,
	input  wire logic sda_i
);
	int unsigned stretch;
	// both lines released, pull-ups hold them high
	initial
	begin
		scl_o      = 1'b1;
		sda_pull_o = 1'b0;
		stretch    = 0;
	end
	// quarter of the 160 ns bus period
	task automatic qtr(input int n);
		repeat (8 * n) @(negedge mclk_i);
	endtask
	// start, or repeated start when scl is low
	task automatic start();
		if (scl_o === 1'b0)
		begin
			qtr(1);
			sda_pull_o = 1'b0;
			qtr(1);
			scl_o = 1'b1;
			// the slave lets go of its ack late, so sda must sit high past the glitch window
			qtr(1);
		end
		qtr(1);
		sda_pull_o = 1'b1;
		qtr(1);
		scl_o = 1'b0;
	endtask
	// stop, then an idle gap so no start follows too soon
	task automatic stop();
		qtr(1);
		sda_pull_o = 1'b1;
		qtr(1);
		scl_o = 1'b1;
		qtr(1);
		sda_pull_o = 1'b0;
		qtr(2);
	endtask
	// one pulse; data moves only while scl is low, sampled mid-high
	task automatic bit_cycle(input logic b, output logic got);
		qtr(1);
		repeat (stretch) @(negedge mclk_i);
		sda_pull_o = ~b;
		qtr(1);
		scl_o = 1'b1;
		qtr(1);
		got = sda_i;
		qtr(1);
		scl_o = 1'b0;
	endtask
	// byte out msb first, sda released for the ack
	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--)
			bit_cycle(d[i], g);
		bit_cycle(1'b1, g);
		ack = ~g;
	endtask
	// byte in; last byte of a read is left unacknowledged
	task automatic read_byte(input logic ack, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--)
		begin
			bit_cycle(1'b1, g);
			d[i] = g;
		end
		bit_cycle(~ack, g);
	endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import gpio_exp_pkg::*;
;
	typedef struct packed {logic [7:0] cmd; logic [7:0] wdata; logic [7:0] rdata;} row_t;
	logic       mclk_i;
	logic       rst_b_i;
	logic       scl;
	logic       sda_pull;
	logic       sda_wire;
	logic       sda_o;
	logic       sda_oe;
	logic [2:0] strap;
	logic [7:0] ext_pins;
	logic [7:0] pins;
	logic [7:0] pin_o;
	logic [7:0] pin_oe;
	logic       int_n_o;
	logic       int_n_oe;
	logic       int_line;
	logic [7:0] d;
	int         n_fail;
	int         checks_done;
	row_t       rows [4] = '{'{8'h01, 8'h55, 8'h55}, '{8'h02, 8'ha5, 8'ha5},
	                         '{8'h03, 8'h0f, 8'h0f}, '{8'h00, 8'hff, 8'h59}};
	logic [7:0] rst_exp [4] = '{8'h3c, 8'hff, 8'h00, 8'hff};
	// wired-and bus with pull-up; pads show drive where enabled
	assign sda_wire = ~sda_pull & ~(sda_oe & ~sda_o);
	assign int_line = ~(int_n_oe & ~int_n_o);
	assign pins     = (pin_oe & pin_o) | (~pin_oe & ext_pins);
	initial
	begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	i2c_master_model i_master (.mclk_i(mclk_i), .scl_o(scl), .sda_pull_o(sda_pull), .sda_i(sda_wire));
	gpio_expander i_dut (
		.mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o),
		.sda_oe_o(sda_oe), .addr_strap_low_i(strap[0]), .addr_strap_mid_i(strap[1]),
		.addr_strap_high_i(strap[2]), .port_pin_bus_i(pins), .port_pin_bus_o(pin_o),
		.port_pin_bus_oe_o(pin_oe), .int_n_o(int_n_o), .int_n_oe_o(int_n_oe));
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// own address with the operation bit last
	function automatic logic [7:0] addr(input logic rd);
		return {ADDR_FIXED, strap, rd};
	endfunction
	task automatic send(input logic [7:0] b, input logic exp_ack);
		logic a;
		i_master.write_byte(b, a);
		check({7'h00, a}, {7'h00, exp_ack});
	endtask
	task automatic wr_reg(input logic [7:0] cmd, input logic [7:0] b);
		i_master.start();
		send(addr(1'b0), 1'b1);
		send(cmd, 1'b1);
		send(b, 1'b1);
		i_master.stop();
	endtask
	// leaves the bus open so the caller can look before the stop
	task automatic rd_reg(input logic [7:0] cmd, output logic [7:0] q);
		i_master.start();
		send(addr(1'b0), 1'b1);
		send(cmd, 1'b1);
		i_master.start();
		send(addr(1'b1), 1'b1);
		i_master.read_byte(1'b0, q);
	endtask
	task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
		logic [7:0] q;
		rd_reg(cmd, q);
		i_master.stop();
		check(q, exp);
	endtask
	// bounded wait on the interrupt drive
	task automatic wait_int(input logic exp);
		int k;
		k = 0;
		while (int_line !== ~exp && k < 200)
		begin
			@(negedge mclk_i);
			k++;
		end
		check({7'h00, int_line}, {7'h00, ~exp});
		if (k == 200)
			tally_and_finish();
	endtask
	initial
	begin
		n_fail = 0;
		checks_done = 0;
		rst_b_i = 1'b0;
		strap = 3'h0;
		ext_pins = 8'h3c;
		repeat (5) @(negedge mclk_i);
		rst_b_i = 1'b1;
		repeat (20) @(negedge mclk_i);
		// defaults after power-up, all pins inputs
		check(pin_oe, 8'h00);
		for (int i = 0; i < 4; i++)
			rd_chk(i[7:0], rst_exp[i]);
		// ordinary register traffic
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(rows[i].cmd, rows[i].wdata);
			rd_chk(rows[i].cmd, rows[i].rdata);
		end
		check(pin_oe, 8'hf0);
		check(pin_o & 8'hf0, 8'h50);
		// slow master, several data bytes to one register
		i_master.stretch = 20;
		i_master.start();
		send(addr(1'b0), 1'b1);
		send(8'h01, 1'b1);
		send(8'h11, 1'b1);
		send(8'h22, 1'b1);
		send(8'h33, 1'b1);
		i_master.stop();
		i_master.stretch = 0;
		check(pin_o & 8'hf0, 8'h30);
		// read without a command byte keeps the last register
		i_master.start();
		send(addr(1'b1), 1'b1);
		i_master.read_byte(1'b1, d);
		check(d, 8'h33);
		i_master.read_byte(1'b0, d);
		check(d, 8'h33);
		repeat (20) @(negedge mclk_i);
		check({7'h00, sda_oe}, 8'h00);
		i_master.stop();
		// every strap setting, with a neighbour address refused
		for (int s = 0; s < 8; s++)
		begin
			strap = s[2:0];
			repeat (10) @(negedge mclk_i);
			i_master.start();
			send({ADDR_FIXED, s[2:0] ^ 3'h1, 1'b0}, 1'b0);
			i_master.stop();
			i_master.start();
			send(addr(1'b1), 1'b1);
			i_master.read_byte(1'b0, d);
			i_master.stop();
			check(d, 8'h33);
		end
		strap = 3'h0;
		repeat (10) @(negedge mclk_i);
		// interrupt: raise, restore, clear on input read, clear on stop
		ext_pins[0] = 1'b1;
		wait_int(1'b1);
		ext_pins[0] = 1'b0;
		wait_int(1'b0);
		ext_pins[2] = 1'b0;
		wait_int(1'b1);
		rd_reg(8'h00, d);
		check({7'h00, int_n_oe}, 8'h00);
		check(d, 8'h3d);
		i_master.stop();
		// output pins switching must not raise it
		i_master.start();
		send(addr(1'b0), 1'b1);
		send(8'h01, 1'b1);
		send(8'hff, 1'b1);
		repeat (10) @(negedge mclk_i);
		check({7'h00, int_n_oe}, 8'h00);
		i_master.stop();
		ext_pins[3] = 1'b0;
		wait_int(1'b1);
		i_master.start();
		i_master.stop();
		wait_int(1'b0);
		// reset in mid-run returns everything to defaults
		wr_reg(8'h03, 8'h00);
		check(pin_oe, 8'hff);
		rst_b_i = 1'b0;
		repeat (5) @(negedge mclk_i);
		check(pin_oe, 8'h00);
		check(pin_o, 8'h00);
		check({7'h00, sda_oe}, 8'h00);
		rst_b_i = 1'b1;
		repeat (20) @(negedge mclk_i);
		rd_chk(8'h03, 8'hff);
		rd_chk(8'h01, 8'hff);
		tally_and_finish();
	end
endmodule
`default_nettype wire

/* File: logic/gpio_exp_pkg.sv */
// Summary of operation
// [RULE_01] input pins have both high-side and low-side drivers switched off
// [RULE_02] output pins are driven high or low from the output latch bit
// [RULE_03] sda falling while scl high starts a transfer; address byte follows
// [RULE_04] address byte arrives msb first, read/write bit last
// [RULE_05] matching address is acknowledged by holding sda low during ack high
// [RULE_06] one bit per scl pulse; sda change during scl high is start/stop
// [RULE_07] sda rising while scl high is stop; slave returns to idle
// [RULE_08] each byte has one ack bit; transmitter releases sda for it
// [RULE_09] as receiver every byte is acknowledged for the whole ack high phase
// [RULE_10] on master nack after a read byte, sda is released for stop
// [RULE_11] master starts a new transfer only while the bus is idle
// [RULE_12] slave address is 0100 plus three strap inputs, 20h to 27h
// [RULE_13] address lsb 1 means read, 0 means write
// [RULE_14] first byte after write address is the command, kept in a pointer
// [RULE_15] low two command bits pick input, latch, polarity or direction register
// [RULE_16] reads keep using the last command until a new one is written
// [RULE_17] input register returns pin levels for all pins; writes are ignored
// [RULE_18] latch reads return latch bits; latch has no effect on input pins
// [RULE_19] polarity bit 1 inverts the reported level of an input pin
// [RULE_20] direction bit 1 makes pin high-impedance input, 0 a driven output
// [RULE_21] reset loads latch all ones, polarity all zeros, direction all ones
// [RULE_22] reset holds all logic; release starts registers and bus fsm at defaults
// [RULE_23] any edge on an input pin raises the active-low interrupt
// [RULE_24] interrupt clears on pins restored, input read ack, or stop
// [RULE_25] after the command any number of data bytes write the chosen register
// [RULE_26] during reads pin levels are captured at the ack clock rising edge
// [RULE_27] scl and sda pass synchronisers and a glitch filter before decoding
`default_nettype none
package gpio_exp_pkg;
	// bus addressing
	localparam logic [3:0] ADDR_FIXED = 4'h4;
	localparam logic [1:0] REG_INPUT     = 2'h0;
	localparam logic [1:0] REG_LATCH     = 2'h1;
	localparam logic [1:0] REG_POLARITY  = 2'h2;
	localparam logic [1:0] REG_DIRECTION = 2'h3;
	// register reset values
	localparam logic [7:0] LATCH_RST = 8'hff;
	localparam logic [7:0] POL_RST   = 8'h00;
	localparam logic [7:0] DIR_RST   = 8'hff;
	localparam logic [7:0] CMD_RST   = 8'h00;
	// bit counting
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] TX_LAST   = 4'h7;
	// timing: longest glitch rounds down to whole cycles
	localparam int MCLK_PERIOD_NS = 5;
	localparam int GLITCH_NS      = 50;
	localparam int GLITCH_CYC     = (GLITCH_NS / MCLK_PERIOD_NS < 1) ? 1 : GLITCH_NS / MCLK_PERIOD_NS;
	localparam int PIN_FILT_CYC   = 1;
	localparam logic [2:0] SETTLE_CYC = 3'h7;
	// slave state machine
	typedef enum logic [4:0] {
		ST_IDLE    = 5'h01,
		ST_RX_BYTE = 5'h02,
		ST_RX_ACK  = 5'h04,
		ST_TX_BYTE = 5'h08,
		ST_TX_ACK  = 5'h10
	} slave_state_t;
	// meaning of the byte being received
	typedef enum logic [2:0] {
		PH_ADDR = 3'h1,
		PH_CMD  = 3'h2,
		PH_DATA = 3'h4
	} rx_phase_t;
endpackage
`default_nettype wire

/* File: logic/gpio_expander.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_expander
	import gpio_exp_pkg::*;
(
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_b_i,
	// serial bus
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output var  logic       sda_o,
	output var  logic       sda_oe_o,
	// address straps
	input  wire logic       addr_strap_low_i,
	input  wire logic       addr_strap_mid_i,
	input  wire logic       addr_strap_high_i,
	// port pins
	input  wire logic [7:0] port_pin_bus_i,
	output var  logic [7:0] port_pin_bus_o,
	output var  logic [7:0] port_pin_bus_oe_o,
	// interrupt, open drain
	output var  logic       int_n_o,
	output var  logic       int_n_oe_o
);
	logic         scl_f;
	logic         sda_f;
	logic         scl_d;
	logic         sda_d;
	logic         scl_rise;
	logic         scl_fall;
	logic         start_det;
	logic         stop_det;
	logic [2:0]   strap_raw;
	logic [2:0]   strap;
	logic [7:0]   pin_level;

	slave_state_t state;
	rx_phase_t    phase;
	logic [3:0]   bit_cnt;
	logic [7:0]   rx_shift;
	logic [7:0]   tx_shift;
	logic         rw_read;
	logic         master_ack;
	logic         sda_drive;
	logic [7:0]   cmd_ptr;

	logic [7:0]   input_levels;
	logic [7:0]   output_latch;
	logic [7:0]   input_polarity_invert;
	logic [7:0]   pin_direction;
	logic         ref_ready;
	logic [2:0]   settle_cnt;

	logic         byte_done;
	logic         addr_match;
	logic         wr_strobe;
	logic         tx_load;
	logic         capture;
	logic [7:0]   tx_next;

	// selected register contents as the master sees them
	function automatic logic [7:0] read_mux(
		input logic [1:0] sel,
		input logic [7:0] lvl,
		input logic [7:0] lat,
		input logic [7:0] pol,
		input logic [7:0] dir
	);
		case (sel) // RULE_15
			REG_INPUT:     read_mux = lvl ^ (pol & dir); // RULE_17 RULE_19
			REG_LATCH:     read_mux = lat; // RULE_18
			REG_POLARITY:  read_mux = pol;
			REG_DIRECTION: read_mux = dir;
			default:       read_mux = 8'h00;
		endcase
	endfunction

	// write decode used by every writable register
	function automatic logic reg_write(
		input logic       strobe,
		input logic [1:0] sel,
		input logic [1:0] which
	);
		reg_write = strobe && (sel == which);
	endfunction

	// bus lines idle high; filtered against spikes before any decode
	line_filter #(
		.FILT_CYC (GLITCH_CYC),
		.RST_VAL  (1'b1)
	) u_scl_filt (
		.mclk_i  (mclk_i),
		.rst_b_i (rst_b_i),
		.line_i  (scl_i),
		.level_o (scl_f) // RULE_27
	);

	line_filter #(
		.FILT_CYC (GLITCH_CYC),
		.RST_VAL  (1'b1)
	) u_sda_filt (
		.mclk_i  (mclk_i),
		.rst_b_i (rst_b_i),
		.line_i  (sda_i),
		.level_o (sda_f) // RULE_27
	);

	assign strap_raw = {addr_strap_high_i, addr_strap_mid_i, addr_strap_low_i};

	// straps and pins are asynchronous, so each gets its own sampler
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_strap
			line_filter #(
				.FILT_CYC (PIN_FILT_CYC),
				.RST_VAL  (1'b0)
			) u_strap (
				.mclk_i  (mclk_i),
				.rst_b_i (rst_b_i),
				.line_i  (strap_raw[gi]),
				.level_o (strap[gi])
			);
		end
		for (gi = 0; gi < 8; gi++)
		begin : g_pin
			line_filter #(
				.FILT_CYC (PIN_FILT_CYC),
				.RST_VAL  (1'b0)
			) u_pin (
				.mclk_i  (mclk_i),
				.rst_b_i (rst_b_i),
				.line_i  (port_pin_bus_i[gi]),
				.level_o (pin_level[gi])
			);
		end
	endgenerate

	// previous filtered levels for edge finding
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			scl_d <= scl_f;
			sda_d <= sda_f;
		end
	end

	// sda moving while scl high is control, never data
	assign scl_rise  = scl_f & ~scl_d;
	assign scl_fall  = ~scl_f & scl_d;
	assign start_det = scl_f & scl_d & sda_d & ~sda_f; // RULE_03 RULE_06
	assign stop_det  = scl_f & scl_d & ~sda_d & sda_f; // RULE_07 RULE_06

	// byte boundary decode
	assign byte_done  = (state == ST_RX_BYTE) && scl_fall && (bit_cnt == BYTE_BITS);
	assign addr_match = (rx_shift[7:1] == {ADDR_FIXED, strap}); // RULE_12
	assign wr_strobe  = byte_done && (phase == PH_DATA); // RULE_25
	assign tx_load    = scl_fall && (((state == ST_RX_ACK) && (phase == PH_ADDR) && rw_read)
	                  || ((state == ST_TX_ACK) && master_ack));
	assign capture    = scl_rise && (cmd_ptr[1:0] == REG_INPUT)
	                  && (((state == ST_RX_ACK) && (phase == PH_ADDR) && rw_read)
	                  || (state == ST_TX_ACK)); // RULE_26
	assign tx_next    = read_mux(cmd_ptr[1:0], input_levels, output_latch,
	                             input_polarity_invert, pin_direction); // RULE_16

	// slave state machine; start and stop override any state
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			state <= ST_IDLE; // RULE_22
		else if (start_det)
			state <= ST_RX_BYTE; // RULE_03
		else if (stop_det)
			state <= ST_IDLE; // RULE_07
		else
		begin
			case (state)
				ST_IDLE:
					state <= ST_IDLE;
				ST_RX_BYTE:
					if (byte_done)
						state <= (phase != PH_ADDR || addr_match) ? ST_RX_ACK : ST_IDLE;
				ST_RX_ACK:
					if (scl_fall)
						state <= (phase == PH_ADDR && rw_read) ? ST_TX_BYTE : ST_RX_BYTE;
				ST_TX_BYTE:
					if (scl_fall && bit_cnt == TX_LAST)
						state <= ST_TX_ACK;
				ST_TX_ACK:
					if (scl_fall)
						state <= master_ack ? ST_TX_BYTE : ST_IDLE; // RULE_10
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// what the next received byte means
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			phase <= PH_ADDR;
		else if (start_det)
			phase <= PH_ADDR;
		else if (state == ST_RX_ACK && scl_fall && phase != PH_DATA)
			phase <= (phase == PH_ADDR) ? PH_CMD : PH_DATA; // RULE_14
	end

	// bit counter: rises while receiving and while sending
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			bit_cnt <= 4'h0;
		else if (start_det)
			bit_cnt <= 4'h0;
		else if (state == ST_RX_BYTE && scl_rise)
			bit_cnt <= bit_cnt + 4'h1;
		else if (state == ST_TX_BYTE && scl_fall)
			bit_cnt <= bit_cnt + 4'h1;
		else if ((state == ST_RX_ACK || state == ST_TX_ACK) && scl_fall)
			bit_cnt <= 4'h0;
	end

	// receive shifter, msb first, sampled at scl rise
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rx_shift <= 8'h00;
		else if (state == ST_RX_BYTE && scl_rise)
			rx_shift <= {rx_shift[6:0], sda_f}; // RULE_04
	end

	// transfer direction from the address lsb
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rw_read <= 1'b0;
		else if (start_det)
			rw_read <= 1'b0;
		else if (byte_done && phase == PH_ADDR)
			rw_read <= rx_shift[0]; // RULE_13
	end

	// command pointer survives restarts and read transfers
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			cmd_ptr <= CMD_RST;
		else if (byte_done && phase == PH_CMD)
			cmd_ptr <= rx_shift; // RULE_14 RULE_16
	end

	// master acknowledge sampled at the ack clock rise
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			master_ack <= 1'b0;
		else if (state == ST_TX_ACK && scl_rise)
			master_ack <= ~sda_f; // RULE_10
	end

	// transmit shifter
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			tx_shift <= 8'h00;
		else if (tx_load)
			tx_shift <= tx_next;
		else if (state == ST_TX_BYTE && scl_fall)
			tx_shift <= {tx_shift[6:0], 1'b0};
	end

	// open-drain data: changes only after scl falls, so it is stable while high
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			sda_drive <= 1'b0;
		else if (start_det || stop_det)
			sda_drive <= 1'b0;
		else if (byte_done)
			sda_drive <= (phase != PH_ADDR || addr_match); // RULE_05 RULE_09
		else if (tx_load)
			sda_drive <= ~tx_next[7];
		else if (state == ST_TX_BYTE && scl_fall)
			sda_drive <= (bit_cnt == TX_LAST) ? 1'b0 : ~tx_shift[6]; // RULE_08
		else if ((state == ST_RX_ACK || state == ST_TX_ACK) && scl_fall)
			sda_drive <= 1'b0; // RULE_08 RULE_10
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = sda_drive;

	// output latch
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			output_latch <= LATCH_RST; // RULE_21
		else if (reg_write(wr_strobe, cmd_ptr[1:0], REG_LATCH))
			output_latch <= rx_shift; // RULE_25
	end

	// polarity inversion
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			input_polarity_invert <= POL_RST; // RULE_21
		else if (reg_write(wr_strobe, cmd_ptr[1:0], REG_POLARITY))
			input_polarity_invert <= rx_shift; // RULE_25
	end

	// pin direction; input register has no write path at all
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			pin_direction <= DIR_RST; // RULE_21
		else if (reg_write(wr_strobe, cmd_ptr[1:0], REG_DIRECTION))
			pin_direction <= rx_shift; // RULE_20 RULE_17
	end

	// wait for the pin samplers to fill before trusting a reference
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			settle_cnt <= 3'h0;
			ref_ready  <= 1'b0;
		end
		else if (!ref_ready)
		begin
			settle_cnt <= settle_cnt + 3'h1;
			ref_ready  <= (settle_cnt == SETTLE_CYC);
		end
	end

	// captured levels double as the interrupt reference
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			input_levels <= 8'h00;
		else if (!ref_ready || capture || stop_det)
			input_levels <= pin_level; // RULE_24 RULE_26
	end

	// compare, not edge latch: a pin that returns clears by itself
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			int_n_oe_o <= 1'b0;
		else
			int_n_oe_o <= ref_ready && |((pin_level ^ input_levels) & pin_direction); // RULE_23 RULE_24
	end

	assign int_n_o = 1'b0;

	port_drive u_port_drive (
		.mclk_i      (mclk_i),
		.rst_b_i     (rst_b_i),
		.direction_i (pin_direction), // RULE_20
		.latch_i     (output_latch), // RULE_18
		.pin_o       (port_pin_bus_o),
		.pin_oe_o    (port_pin_bus_oe_o)
	);

	// checks on the device's own behaviour
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_input_hiz: assert property ((port_pin_bus_oe_o & $past(pin_direction)) == 8'h00) // RULE_01
		else $error("input pin is being driven");

	a_output_level: assert property (((port_pin_bus_o ^ $past(output_latch)) & ~$past(pin_direction)) == 8'h00
		&& port_pin_bus_oe_o == ~$past(pin_direction)) // RULE_02
		else $error("output pin does not follow latch");

	a_start_addr: assert property (start_det |=> state == ST_RX_BYTE && phase == PH_ADDR && bit_cnt == 4'h0) // RULE_03
		else $error("start did not arm address reception");

	a_addr_ack: assert property ((byte_done && phase == PH_ADDR && addr_match) |=> state == ST_RX_ACK && sda_oe_o) // RULE_05
		else $error("own address not acknowledged");

	a_addr_miss: assert property ((byte_done && phase == PH_ADDR && !addr_match) |=> state == ST_IDLE && !sda_oe_o) // RULE_12
		else $error("foreign address answered");

	a_ack_held: assert property ((state == ST_RX_ACK && scl_rise) |-> sda_oe_o ##1 sda_oe_o) // RULE_09
		else $error("receive ack not held low");

	a_stop_idle: assert property (stop_det |=> state == ST_IDLE && !sda_oe_o) // RULE_07
		else $error("stop did not return to idle");

	a_nack_release: assert property ((state == ST_TX_ACK && scl_fall && !master_ack) |=> !sda_oe_o && state == ST_IDLE) // RULE_10
		else $error("sda not released after nack");

	a_input_ro: assert property ((wr_strobe && cmd_ptr[1:0] == REG_INPUT) |=> $stable(output_latch)
		&& $stable(input_polarity_invert) && $stable(pin_direction)) // RULE_17
		else $error("write to input register changed state");

	a_output_no_irq: assert property ((((pin_level ^ input_levels) & pin_direction) == 8'h00) |=> !int_n_oe_o) // RULE_23
		else $error("interrupt without input change");

	a_tx_first_bit: assert property (tx_load |=> sda_oe_o == ~tx_shift[7] && state == ST_TX_BYTE) // RULE_08
		else $error("first read bit not presented");

	c_read_byte: cover property (tx_load && cmd_ptr[1:0] == REG_INPUT);
	c_dir_write: cover property (reg_write(wr_strobe, cmd_ptr[1:0], REG_DIRECTION));
	c_read_nack: cover property (state == ST_TX_ACK && scl_fall && !master_ack);
	c_irq_raise: cover property (!int_n_oe_o ##1 int_n_oe_o);
endmodule
`default_nettype wire

/* File: logic/line_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module line_filter
	import gpio_exp_pkg::*;
#(
	parameter int   FILT_CYC = 1,
	parameter logic RST_VAL  = 1'b0
)(
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_b_i,
	// raw line in, clean level out
	input  wire logic line_i,
	output var  logic level_o
);
	localparam logic [3:0] LIMIT = 4'(FILT_CYC - 1);

	logic       s1;
	logic       s2;
	logic       s3;
	logic [3:0] stable_cnt;

	// three-stage sampler; s1 is seen by s2 only
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
		end
		else
		begin
			s1 <= line_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a new level must hold for the whole window, so spikes die here
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			stable_cnt <= 4'h0;
		else if (s2 != s3 || s3 == level_o || stable_cnt == LIMIT)
			stable_cnt <= 4'h0;
		else
			stable_cnt <= stable_cnt + 4'h1;
	end

	// accept only once the second and third stages agree
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			level_o <= RST_VAL;
		else if (s2 == s3 && s3 != level_o && stable_cnt == LIMIT)
			level_o <= s3;
	end
endmodule
`default_nettype wire

/* File: logic/port_drive.sv */
`timescale 1ns/1ps
`default_nettype none
module port_drive
	import gpio_exp_pkg::*;
(
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_b_i,
	// register state
	input  wire logic [7:0] direction_i,
	input  wire logic [7:0] latch_i,
	// pad drive
	output var  logic [7:0] pin_o,
	output var  logic [7:0] pin_oe_o
);
	logic [7:0] high_side_driver;
	logic [7:0] low_side_driver;

	// direction 1 keeps both drivers off, whatever the latch holds
	assign high_side_driver = ~direction_i & latch_i;
	assign low_side_driver  = ~direction_i & ~latch_i;

	// registered so pads never see decode glitches
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			pin_o    <= 8'h00;
			pin_oe_o <= 8'h00;
		end
		else
		begin
			pin_o    <= high_side_driver; // RULE_02
			pin_oe_o <= high_side_driver | low_side_driver; // RULE_01
		end
	end
endmodule
`default_nettype wire
